// file: spf_flash_ctrl.sv
// Store-program-memory control, page operation timing and lock protection.
//
// The implementer's own choices: register access over APB and the address map.
module spf_flash_ctrl #(
    parameter int unsigned PROG_CYCLES = spf_pkg::PROG_CYCLES_MIN,
    parameter int          OP_W        = 20,
    parameter int          WORD_BITS   = 5,
    parameter int          PAGE_BITS   = 6
) (
    input  wire logic                 REF_CLK_IN,
    input  wire logic                 RST_N_IN,
    input  wire logic                 POR_N_IN,
    input  wire logic                 PSEL_IN,
    input  wire logic                 PENABLE_IN,
    input  wire logic                 PWRITE_IN,
    input  wire logic [7:0]           PADDR_IN,
    input  wire logic [31:0]          PWDATA_IN,
    output logic      [31:0]          PRDATA_OUT,
    output logic                      PREADY_OUT,
    output logic                      PSLVERR_OUT,
    input  wire logic                 STORE_INSTR_IN,
    input  wire logic                 LOAD_INSTR_IN,
    input  wire logic [15:0]          ZPTR_IN,
    input  wire logic [15:0]          STORE_DATA_IN,
    input  wire logic [7:0]           FUSE_LOW_IN,
    input  wire logic [7:0]           FUSE_HIGH_IN,
    input  wire logic                 CHIP_ERASE_IN,
    input  wire logic [WORD_BITS-1:0] FLASH_RD_IDX_IN,
    output logic      [15:0]          FLASH_RD_DATA_OUT,
    output logic                      FLASH_START_OUT,
    output logic                      FLASH_ERASE_OUT,
    output logic                      FLASH_PROG_OUT,
    output logic      [PAGE_BITS-1:0] FLASH_PAGE_OUT,
    output logic                      CPU_HALT_OUT,
    output logic                      LOAD_VALID_OUT,
    output logic      [7:0]           LOAD_DATA_OUT,
    output logic                      EXT_PROG_EN_OUT,
    output logic                      EXT_VERIFY_EN_OUT,
    output logic                      FUSE_WRITE_EN_OUT,
    output logic                      DEBUG_PORT_EN_OUT,
    output logic                      DEBUG_MEM_READ_EN_OUT
);
    spf_pkg::spf_op_t     op_q;
    spf_pkg::spf_op_t     op_d;
    logic [4:0]           cmd_q;
    logic [4:0]           cmd_d;
    logic [1:0]           lock_q;
    logic [1:0]           lock_wdata_q;
    logic [PAGE_BITS-1:0] page_q;
    logic                 start_q;
    logic                 pready_q;
    logic                 pslverr_q;
    logic [31:0]          prdata_q;
    logic                 load_valid_q;
    logic [7:0]           load_data_q;
    logic [4:0]           prot_q;
    logic [2:0]           arm_cnt;
    logic                 arm_done;
    logic [OP_W-1:0]      op_cnt;
    logic                 op_done;
    logic                 halt_q;
    logic                 erase_q;
    logic                 prog_q;

    spf_buf_if #(.WORD_BITS(WORD_BITS), .DATA_W(16)) buf_if ();

    // APB: one wait state, the answer is registered in the first access cycle.
    wire apb_access  = PSEL_IN && PENABLE_IN;
    wire apb_first   = apb_access && !pready_q;
    wire apb_done    = apb_access && pready_q;
    wire sel_ctrl    = (PADDR_IN == spf_pkg::CTRL_OFFSET);
    wire sel_status  = (PADDR_IN == spf_pkg::STATUS_OFFSET);
    wire busy        = (op_q != spf_pkg::OP_IDLE);
    wire armed       = (arm_cnt != 3'h0);

    wire [4:0] wr_cmd = PWDATA_IN[4:0];
    wire cmd_legal = (wr_cmd == spf_pkg::CMD_CLEAR_BUF) || (wr_cmd == spf_pkg::CMD_FUSE_LOCK)
                  || (wr_cmd == spf_pkg::CMD_PAGE_PROG) || (wr_cmd == spf_pkg::CMD_PAGE_ERASE)
                  || (wr_cmd == spf_pkg::CMD_LOAD_WORD);
    // The core is halted while busy, so writes then can only come from a stray master.
    wire arm_wr    = apb_done && PWRITE_IN && sel_ctrl && !busy && cmd_legal;

    wire store_go  = STORE_INSTR_IN && armed && !busy && cmd_q[spf_pkg::BIT_STORE_EN];
    wire load_go   = LOAD_INSTR_IN && armed && (cmd_q == spf_pkg::CMD_FUSE_LOCK)
                  && (arm_cnt > (spf_pkg::ARM_CYCLES - spf_pkg::LOAD_CYCLES));
    wire go_erase  = store_go && (cmd_q == spf_pkg::CMD_PAGE_ERASE);
    wire go_prog   = store_go && (cmd_q == spf_pkg::CMD_PAGE_PROG);
    wire go_lock   = store_go && (cmd_q == spf_pkg::CMD_FUSE_LOCK);
    wire op_start  = go_erase || go_prog || go_lock;

    // The Z pointer low byte bit carries byte select, so word and page sit above it.
    wire [WORD_BITS-1:0] z_word = ZPTR_IN[WORD_BITS:1];
    wire [PAGE_BITS-1:0] z_page = ZPTR_IN[WORD_BITS+PAGE_BITS:WORD_BITS+1];

    // Buffer survives a system reset that lands inside a page program.
    wire buf_rst_n = POR_N_IN && (RST_N_IN || busy);
    wire sys_rst   = !POR_N_IN || (!RST_N_IN && !busy);

    assign buf_if.wr     = store_go && (cmd_q == spf_pkg::CMD_LOAD_WORD);
    assign buf_if.idx    = z_word;
    assign buf_if.wdata  = STORE_DATA_IN;
    assign buf_if.clear  = (arm_wr && (wr_cmd == spf_pkg::CMD_CLEAR_BUF))
                        || (op_done && (op_q == spf_pkg::OP_PROG));
    assign buf_if.rd_idx = FLASH_RD_IDX_IN;

    spf_page_buffer #(
        .WORD_BITS (WORD_BITS),
        .DATA_W    (16)
    ) u_buffer (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (buf_rst_n),
        .bus      (buf_if.store)
    );

    // Arming window: four cycles for a store, the first three also for a load.
    spf_countdown #(
        .W (3)
    ) u_arm (
        .clk_in    (REF_CLK_IN),
        .rst_n_in  (!sys_rst),
        .load_in   (arm_wr),
        .value_in  (spf_pkg::ARM_CYCLES),
        .stop_in   (store_go || load_go),
        .count_out (arm_cnt),
        .done_out  (arm_done)
    );

    // Operation timer runs off power-on reset only, so a system reset cannot cut it short.
    spf_countdown #(
        .W (OP_W)
    ) u_optime (
        .clk_in    (REF_CLK_IN),
        .rst_n_in  (POR_N_IN),
        .load_in   (op_start),
        .value_in  (OP_W'(PROG_CYCLES)),
        .stop_in   (1'b0),
        .count_out (op_cnt),
        .done_out  (op_done)
    );

    always_comb
    begin
        op_d = op_q;
        case (op_q)
            spf_pkg::OP_IDLE:
            begin
                if (go_erase)
                    op_d = spf_pkg::OP_ERASE;
                else if (go_prog)
                    op_d = spf_pkg::OP_PROG;
                else if (go_lock)
                    op_d = spf_pkg::OP_LOCK;
            end
            default:
            begin
                if (op_done)
                    op_d = spf_pkg::OP_IDLE;
            end
        endcase
    end

    always_comb
    begin
        cmd_d = cmd_q;
        if (arm_wr)
            cmd_d = wr_cmd;
        else if (busy)
        begin
            if (op_done)
                cmd_d = spf_pkg::CTRL_RESET;
        end
        else if (op_start)
            cmd_d = cmd_q;
        else if (store_go || load_go || arm_done)
            cmd_d = spf_pkg::CTRL_RESET;
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!POR_N_IN)
            op_q <= spf_pkg::OP_IDLE;
        else
            op_q <= op_d;
    end

    // Outputs are registered from the next state, so they line up with op_q exactly.
    wire halt_d  = (op_d != spf_pkg::OP_IDLE);
    wire erase_d = (op_d == spf_pkg::OP_ERASE);
    wire prog_d  = (op_d == spf_pkg::OP_PROG) || (op_d == spf_pkg::OP_LOCK);

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!POR_N_IN)
        begin
            halt_q  <= 1'b0;
            erase_q <= 1'b0;
            prog_q  <= 1'b0;
        end
        else
        begin
            halt_q  <= halt_d;
            erase_q <= erase_d;
            prog_q  <= prog_d;
        end
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (sys_rst)
            cmd_q <= spf_pkg::CTRL_RESET;
        else
            cmd_q <= cmd_d;
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!POR_N_IN)
        begin
            page_q       <= '0;
            lock_wdata_q <= spf_pkg::LOCK_RESET;
        end
        else if (op_start)
        begin
            page_q       <= z_page;
            lock_wdata_q <= STORE_DATA_IN[1:0];
        end
    end

    // Lock bits can only be programmed towards zero; power-on reset and chip erase alone set them.
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!POR_N_IN || CHIP_ERASE_IN)
            lock_q <= spf_pkg::LOCK_RESET;
        else if (op_done && (op_q == spf_pkg::OP_LOCK))
            lock_q <= lock_q & lock_wdata_q;
    end

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!POR_N_IN)
            start_q <= 1'b0;
        else
            start_q <= op_start;
    end

    // Lock byte pads unused bits as unprogrammed ones.
    wire [7:0] lock_byte = {6'h3f, lock_q};
    wire [7:0] fuse_sel  = ZPTR_IN[1] ? FUSE_HIGH_IN : FUSE_LOW_IN;
    wire [7:0] read_byte = ZPTR_IN[0] && !ZPTR_IN[1] ? lock_byte : fuse_sel;

    always_ff @(posedge REF_CLK_IN)
    begin
        if (sys_rst)
        begin
            load_valid_q <= 1'b0;
            load_data_q  <= 8'h00;
        end
        else
        begin
            load_valid_q <= load_go;
            load_data_q  <= load_go ? read_byte : load_data_q;
        end
    end

    // Order: ext prog, ext verify, fuse write, debug port, debug memory read.
    wire lb_low_prog  = !lock_q[0];
    wire lb_high_prog = !lock_q[1];
    wire dbg_fuse     = !FUSE_HIGH_IN[spf_pkg::FUSE_DEBUG_BIT];
    wire any_lock     = lb_low_prog || lb_high_prog;
    wire [4:0] prot_d = {!any_lock,
                         !lb_high_prog,
                         !any_lock,
                         dbg_fuse && !any_lock,
                         dbg_fuse};

    always_ff @(posedge REF_CLK_IN)
    begin
        if (!POR_N_IN)
            prot_q <= 5'h00;
        else
            prot_q <= prot_d;
    end

    wire [31:0] ctrl_rd   = {27'h0, cmd_q};
    wire [31:0] status_rd = {28'h0000000, armed, busy, lock_q};
    wire [31:0] rd_mux    = sel_ctrl ? ctrl_rd : (sel_status ? status_rd : 32'h00000000);

    always_ff @(posedge REF_CLK_IN)
    begin
        if (sys_rst)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end
        else
        begin
            pready_q  <= apb_first;
            pslverr_q <= apb_first && !sel_ctrl && !sel_status;
            prdata_q  <= (apb_first && !PWRITE_IN) ? rd_mux : 32'h00000000;
        end
    end

    assign PRDATA_OUT            = prdata_q;
    assign PREADY_OUT            = pready_q;
    assign PSLVERR_OUT           = pslverr_q;
    assign FLASH_RD_DATA_OUT     = buf_if.rd_data;
    assign FLASH_START_OUT       = start_q;
    assign FLASH_ERASE_OUT       = erase_q;
    assign FLASH_PROG_OUT        = prog_q;
    assign FLASH_PAGE_OUT        = page_q;
    assign CPU_HALT_OUT          = halt_q;
    assign LOAD_VALID_OUT        = load_valid_q;
    assign LOAD_DATA_OUT         = load_data_q;
    assign EXT_PROG_EN_OUT       = prot_q[4];
    assign EXT_VERIFY_EN_OUT     = prot_q[3];
    assign FUSE_WRITE_EN_OUT     = prot_q[2];
    assign DEBUG_PORT_EN_OUT     = prot_q[1];
    assign DEBUG_MEM_READ_EN_OUT = prot_q[0];
endmodule : spf_flash_ctrl

// file: spf_pkg.sv
// Shared constants and types of the self-programming flash controller.
package spf_pkg;

    localparam int unsigned CLK_PERIOD_NS     = 5;
    localparam int unsigned PROG_TIME_MIN_NS  = 3700000;
    localparam int unsigned PROG_TIME_MAX_NS  = 4500000;
    localparam int unsigned PROG_CYCLES_MIN   = (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS;
    localparam int unsigned PROG_CYCLES_MAX   = PROG_TIME_MAX_NS / CLK_PERIOD_NS;

    localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET     = 8'h04;
    localparam logic [4:0]  CTRL_RESET        = 5'h00;
    localparam logic [1:0]  LOCK_RESET        = 2'h3;

    localparam int unsigned BIT_STORE_EN      = 0;
    localparam int unsigned STAT_LOCK_LSB     = 0;
    localparam int unsigned STAT_BUSY         = 2;
    localparam int unsigned STAT_ARMED        = 3;
    localparam int unsigned FUSE_DEBUG_BIT    = 6;

    localparam logic [4:0]  CMD_CLEAR_BUF     = 5'h11;
    localparam logic [4:0]  CMD_FUSE_LOCK     = 5'h09;
    localparam logic [4:0]  CMD_PAGE_PROG     = 5'h05;
    localparam logic [4:0]  CMD_PAGE_ERASE    = 5'h03;
    localparam logic [4:0]  CMD_LOAD_WORD     = 5'h01;

    localparam logic [2:0]  ARM_CYCLES        = 3'h4;
    localparam logic [2:0]  LOAD_CYCLES       = 3'h3;

    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROG, OP_LOCK} spf_op_t;

endpackage : spf_pkg

// file: spf_buf_if.sv
// Connection between the controller and its temporary page buffer.
interface spf_buf_if #(
    parameter int WORD_BITS = 5,
    parameter int DATA_W    = 16
);
    logic                 wr;
    logic                 clear;
    logic [WORD_BITS-1:0] idx;
    logic [DATA_W-1:0]    wdata;
    logic [WORD_BITS-1:0] rd_idx;
    logic [DATA_W-1:0]    rd_data;

    modport ctrl  (output wr, output clear, output idx, output wdata, output rd_idx,
                   input rd_data);
    modport store (input wr, input clear, input idx, input wdata, input rd_idx,
                   output rd_data);
endinterface : spf_buf_if

// file: spf_countdown.sv
// Loadable down counter that flags the cycle in which it runs out.
module spf_countdown #(
    parameter int W = 3
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] value_in,
    input  wire logic         stop_in,
    output logic [W-1:0]      count_out,
    output logic              done_out
);
    logic [W-1:0] count_q;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            count_q <= '0;
        else if (load_in)
            count_q <= value_in;
        else if (stop_in)
            count_q <= '0;
        else if (count_q != '0)
            count_q <= count_q - W'(1);
    end

    assign count_out = count_q;
    assign done_out  = (count_q == W'(1)) && !load_in && !stop_in;
endmodule : spf_countdown

// file: spf_page_buffer.sv
// Temporary page buffer with a written mark per word.
module spf_page_buffer #(
    parameter int WORD_BITS = 5,
    parameter int DATA_W    = 16
) (
    input  wire logic   clk_in,
    input  wire logic   rst_n_in,
    spf_buf_if.store    bus
);
    localparam int DEPTH = 1 << WORD_BITS;

    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [DEPTH-1:0]  written_q;
    logic [DATA_W-1:0] rd_q;

    // A word may be loaded once only; a second load is ignored until the next clear.
    wire load_ok = bus.wr && !written_q[bus.idx];

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || bus.clear)
            written_q <= '0;
        else if (load_ok)
            written_q[bus.idx] <= 1'b1;
    end

    always_ff @(posedge clk_in)
    begin
        if (load_ok)
            mem_q[bus.idx] <= bus.wdata;
    end

    // Cleared words read back as erased flash.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            rd_q <= '1;
        else
            rd_q <= written_q[bus.rd_idx] ? mem_q[bus.rd_idx] : '1;
    end

    assign bus.rd_data = rd_q;
endmodule : spf_page_buffer

// file: spf_flash_ctrl_asserts.sv
// Concurrent checks on the ports of the flash controller, bound to its top module.
module spf_flash_ctrl_asserts #(
    parameter int unsigned PROG_CYCLES = 20
) (
    input wire logic        REF_CLK_IN,
    input wire logic        POR_N_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [7:0]  PADDR_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        STORE_INSTR_IN,
    input wire logic        LOAD_INSTR_IN,
    input wire logic [7:0]  FUSE_HIGH_IN,
    input wire logic        FLASH_START_OUT,
    input wire logic        FLASH_ERASE_OUT,
    input wire logic        FLASH_PROG_OUT,
    input wire logic        CPU_HALT_OUT,
    input wire logic        LOAD_VALID_OUT,
    input wire logic        EXT_PROG_EN_OUT,
    input wire logic        EXT_VERIFY_EN_OUT,
    input wire logic        FUSE_WRITE_EN_OUT,
    input wire logic        DEBUG_PORT_EN_OUT,
    input wire logic        DEBUG_MEM_READ_EN_OUT
);
    // Only the power-on reset aborts an operation, so the system reset must not mask checks.
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!POR_N_IN);
    logic [31:0] halt_cnt_q;
    logic [2:0]  since_wr_q;
    wire         rd_acc  = PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN;
    wire         ctrl_wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN
                           && PADDR_IN == spf_pkg::CTRL_OFFSET;
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!POR_N_IN)
        begin
            halt_cnt_q <= 32'h0;
            since_wr_q <= 3'h7;
        end
        else
        begin
            halt_cnt_q <= CPU_HALT_OUT ? halt_cnt_q + 32'h1 : 32'h0;
            since_wr_q <= ctrl_wr ? 3'h0 : (since_wr_q == 3'h7 ? 3'h7 : since_wr_q + 3'h1);
        end
    end
    a_reserved_zero: assert property (rd_acc && PADDR_IN == spf_pkg::CTRL_OFFSET
        |-> PRDATA_OUT[31:5] == 27'h0) else $error("reserved control bits not zero");
    a_op_length: assert property ($fell(CPU_HALT_OUT) |-> halt_cnt_q == PROG_CYCLES)
        else $error("flash operation length wrong");
    a_halt_one_op: assert property (CPU_HALT_OUT |-> FLASH_ERASE_OUT != FLASH_PROG_OUT)
        else $error("halt without exactly one operation");
    a_start_cause: assert property (FLASH_START_OUT |-> CPU_HALT_OUT && $past(STORE_INSTR_IN))
        else $error("operation start without store");
    a_load_cause: assert property (LOAD_VALID_OUT |-> $past(LOAD_INSTR_IN))
        else $error("load answer without load");
    a_arm_expiry: assert property (STORE_INSTR_IN && since_wr_q >= 3'h4 |=> !FLASH_START_OUT)
        else $error("store accepted after arming expired");
    a_lock_order: assert property (EXT_PROG_EN_OUT |-> EXT_VERIFY_EN_OUT && FUSE_WRITE_EN_OUT)
        else $error("programming allowed while verify or fuses locked");
    a_debug_lock: assert property (DEBUG_PORT_EN_OUT |-> EXT_PROG_EN_OUT)
        else $error("debug port open under lock");
    a_debug_read: assert property ($past(POR_N_IN) && !$past(FUSE_HIGH_IN[6])
        |-> DEBUG_MEM_READ_EN_OUT) else $error("debug read closed with fuse set");
endmodule : spf_flash_ctrl_asserts

bind spf_flash_ctrl spf_flash_ctrl_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
    .REF_CLK_IN(REF_CLK_IN), .POR_N_IN(POR_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .STORE_INSTR_IN(STORE_INSTR_IN), .LOAD_INSTR_IN(LOAD_INSTR_IN),
    .FUSE_HIGH_IN(FUSE_HIGH_IN), .FLASH_START_OUT(FLASH_START_OUT),
    .FLASH_ERASE_OUT(FLASH_ERASE_OUT), .FLASH_PROG_OUT(FLASH_PROG_OUT),
    .CPU_HALT_OUT(CPU_HALT_OUT), .LOAD_VALID_OUT(LOAD_VALID_OUT),
    .EXT_PROG_EN_OUT(EXT_PROG_EN_OUT), .EXT_VERIFY_EN_OUT(EXT_VERIFY_EN_OUT),
    .FUSE_WRITE_EN_OUT(FUSE_WRITE_EN_OUT), .DEBUG_PORT_EN_OUT(DEBUG_PORT_EN_OUT),
    .DEBUG_MEM_READ_EN_OUT(DEBUG_MEM_READ_EN_OUT));

// file: spf_core_model.sv
// Behavioural processor core that issues store and load instructions.
module spf_core_model (
    input  wire logic        clk_in,
    input  wire logic        load_valid_in,
    input  wire logic [7:0]  load_data_in,
    output logic             store_out,
    output logic             load_out,
    output logic [15:0]      zptr_out,
    output logic [15:0]      data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        store_out = 1'b0;
        load_out  = 1'b0;
        zptr_out  = 16'h0000;
        data_out  = 16'h0000;
    end
    // A late store lets the bench probe the end of the arming window.
    task automatic do_store(input int dly, input logic [15:0] z, input logic [15:0] d);
        repeat (dly) @(posedge clk_in);
        zptr_out  <= z;
        data_out  <= d;
        store_out <= 1'b1;
        @(posedge clk_in);
        store_out <= 1'b0;
        data_out  <= ~d;
    endtask : do_store
    // The pointer selects lock bits, low or high fuse byte.
    task automatic do_load(input logic [15:0] z, output logic [7:0] v, output logic ok);
        zptr_out <= z;
        load_out <= 1'b1;
        @(posedge clk_in);
        load_out <= 1'b0;
        zptr_out <= ~z;
        #1;
        ok = load_valid_in;
        v  = load_data_in;
    endtask : do_load
endmodule : spf_core_model

// file: testbench.sv
// Self-checking bench for the self-programming flash controller.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PC = 20;
    localparam logic [7:0]  CT = spf_pkg::CTRL_OFFSET;
    localparam logic [7:0]  ST = spf_pkg::STATUS_OFFSET;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        por_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  fuse_lo = 8'h5a;
    logic [7:0]  fuse_hi = 8'ha5;
    logic        chip_er = 1'b0;
    logic [4:0]  rd_idx = 5'h00;
    wire  logic [31:0] prdata;
    wire  logic        pready, pslverr, st, ld, fstart, ferase, fprog, halt, lvalid;
    wire  logic [15:0] zptr, sdata, rd_word;
    wire  logic [5:0]  fpage;
    wire  logic [7:0]  ldata;
    wire  logic        pe, ve, fw, de, dr;
    int          fails = 0;
    int          samples_checked = 0;
    always #2.5 clk = ~clk;
    spf_flash_ctrl #(.PROG_CYCLES(PC)) i_dut (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .POR_N_IN(por_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .STORE_INSTR_IN(st), .LOAD_INSTR_IN(ld), .ZPTR_IN(zptr), .STORE_DATA_IN(sdata),
        .FUSE_LOW_IN(fuse_lo), .FUSE_HIGH_IN(fuse_hi), .CHIP_ERASE_IN(chip_er),
        .FLASH_RD_IDX_IN(rd_idx), .FLASH_RD_DATA_OUT(rd_word), .FLASH_START_OUT(fstart),
        .FLASH_ERASE_OUT(ferase), .FLASH_PROG_OUT(fprog), .FLASH_PAGE_OUT(fpage),
        .CPU_HALT_OUT(halt), .LOAD_VALID_OUT(lvalid), .LOAD_DATA_OUT(ldata),
        .EXT_PROG_EN_OUT(pe), .EXT_VERIFY_EN_OUT(ve), .FUSE_WRITE_EN_OUT(fw),
        .DEBUG_PORT_EN_OUT(de), .DEBUG_MEM_READ_EN_OUT(dr));
    spf_core_model i_core (.clk_in(clk), .load_valid_in(lvalid), .load_data_in(ldata),
        .store_out(st), .load_out(ld), .zptr_out(zptr), .data_out(sdata));
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
        begin
            fails++;
            tally_and_finish();
        end
        else
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask : rd_check
    task automatic peek(input logic [4:0] idx, input logic [15:0] exp);
        rd_idx <= idx;
        repeat (2) @(posedge clk);
        check(32'(rd_word), 32'(exp));
    endtask : peek
    task automatic rd_fuse(input logic [15:0] z, input logic [8:0] exp);
        logic [7:0] v;
        logic       ok;
        wr(CT, 32'(spf_pkg::CMD_FUSE_LOCK));
        i_core.do_load(z, v, ok);
        check(32'({ok, v}), 32'(exp));
    endtask : rd_fuse
    task automatic wait_idle;
        int n;
        n = 0;
        @(posedge clk);
        while (halt !== 1'b0 && n < PC + 40)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= PC + 40)
        begin
            fails++;
            tally_and_finish();
        end
    endtask : wait_idle
    initial
    begin
        logic [31:0] r;
        logic        e;
        repeat (12) @(posedge clk);
        por_n <= 1'b1;
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_check(CT, 32'h0);
        rd_check(ST, 32'h3);
        check(32'({pe, ve, fw, de, dr}), 32'h1f);
        apb(1'b0, 8'h08, 32'h0, r, e);
        check(32'(e), 32'h1);
        $display("test reset done");
        for (int i = 0; i < 32; i++)
        begin
            wr(CT, {24'h0, 3'h7, i[4:0]});
            apb(1'b0, CT, 32'h0, r, e);
            check(r, (i inside {1, 3, 5, 9, 17}) ? 32'(i) : 32'h0);
            repeat (6) @(posedge clk);
        end
        $display("test patterns done");
        wr(CT, 32'(spf_pkg::CMD_LOAD_WORD));
        i_core.do_store(0, 16'h0147, 16'h1234);
        peek(5'd3, 16'h1234);
        rd_check(CT, 32'h0);
        wr(CT, 32'(spf_pkg::CMD_LOAD_WORD));
        i_core.do_store(2, 16'h0009, 16'h4444);
        peek(5'd4, 16'h4444);
        wr(CT, 32'(spf_pkg::CMD_LOAD_WORD));
        i_core.do_store(3, 16'h000b, 16'h5555);
        peek(5'd5, 16'hffff);
        wr(CT, 32'(spf_pkg::CMD_CLEAR_BUF));
        peek(5'd3, 16'hffff);
        $display("test buffer done");
        wr(CT, 32'(spf_pkg::CMD_PAGE_ERASE));
        i_core.do_store(3, 16'h0140, 16'h0);
        @(posedge clk);
        check(32'({fstart, halt}), 32'h0);
        wr(CT, 32'(spf_pkg::CMD_PAGE_ERASE));
        i_core.do_store(0, 16'h0140, 16'h0);
        @(posedge clk);
        check(32'({fstart, ferase, halt, fprog, fpage}), 32'h385);
        wr(CT, 32'(spf_pkg::CMD_LOAD_WORD));
        rd_check(CT, 32'(spf_pkg::CMD_PAGE_ERASE));
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check(32'(halt), 32'h1);
        wait_idle();
        rd_check(CT, 32'h0);
        wr(CT, 32'(spf_pkg::CMD_PAGE_PROG));
        i_core.do_store(0, 16'h0140, 16'h0);
        @(posedge clk);
        check(32'({fprog, halt, ferase}), 32'h6);
        wait_idle();
        rd_check(CT, 32'h0);
        $display("test page operations done");
        rd_fuse(16'h0000, 9'h15a);
        rd_fuse(16'h0003, 9'h1a5);
        wr(CT, 32'(spf_pkg::CMD_FUSE_LOCK));
        i_core.do_store(0, 16'h0000, 16'hfffe);
        wait_idle();
        repeat (2) @(posedge clk);
        check(32'({pe, ve, fw, de, dr}), 32'h09);
        rd_fuse(16'h0001, 9'h1fe);
        wr(CT, 32'(spf_pkg::CMD_FUSE_LOCK));
        i_core.do_store(0, 16'h0000, 16'hfffc);
        wait_idle();
        repeat (2) @(posedge clk);
        check(32'({pe, ve, fw, de, dr}), 32'h01);
        rd_check(ST, 32'h0);
        chip_er <= 1'b1;
        @(posedge clk);
        chip_er <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'({pe, ve, fw, de, dr}), 32'h1f);
        $display("test locks done");
        tally_and_finish();
    end
endmodule : testbench
